// [rtl/mbrc_pkg.sv]
// Purpose: Shared constants and types for the brake release control
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Frequency and torque values are unsigned drive-scaled words
package mbrc_pkg;

   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SELECT = 8'h04;
   localparam logic [7:0] OFS_FLIM_ONE = 8'h08;
   localparam logic [7:0] OFS_FLIM_TWO = 8'h0C;
   localparam logic [7:0] OFS_TLIM = 8'h10;
   localparam logic [7:0] OFS_ON_DELAY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // Field positions
   localparam int unsigned CTRL_TORQUE_EN_BIT = 0;
   localparam int unsigned SEL_ONE_LSB = 0;
   localparam int unsigned SEL_TWO_LSB = 4;
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_RELEASE_BIT = 2;
   localparam int unsigned STAT_COUNT_LSB = 16;

   // Selector codes
   localparam logic [2:0] SEL_SPLIT = 3'h3;
   localparam logic [2:0] SEL_SHARED = 3'h4;

   // Reset values
   localparam logic [15:0] RST_LIMIT = 16'h0000;
   localparam logic [15:0] RST_ON_DELAY = 16'h0064;
   localparam logic [2:0] RST_SEL = 3'h0;

   // Delay counting unit: one millisecond
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

   typedef enum logic [1:0] {
      MBRC_CLOSED = 2'b00,
      MBRC_RELEASED = 2'b01,
      MBRC_STOPPING = 2'b10
   } mbrc_state_t;

   typedef struct packed {
      logic torque_en;
      logic [2:0] sel_one;
      logic [2:0] sel_two;
      logic [15:0] flim_one;
      logic [15:0] flim_two;
      logic [15:0] tlim;
      logic [15:0] on_delay;
   } mbrc_cfg_t;

   typedef struct packed {
      logic run;
      logic stop_cmd;
      logic stopped;
      logic fault;
      logic [15:0] torque;
      logic [15:0] freq;
   } mbrc_drive_t;

endpackage

// [rtl/mbrc_tick_div.sv]
// Purpose: Divides the clock into a one-cycle tick enable
// Assumes: DIV of at least two cycles
// Notes: Restart realigns the tick so a count starts on a full period
`timescale 1ns/1ps
`default_nettype none
module mbrc_tick_div #(
   parameter int unsigned DIV = 125000
) (
   input wire logic clk,         // System clock
   input wire logic reset,       // Synchronous reset, active high
   input wire logic restart,     // Realign the divider
   output logic tick             // One-cycle tick pulse
);
   localparam int unsigned CW = $clog2(DIV);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   wire last = (cnt_reg == CW'(DIV - 1));

   generate
      if (DIV < 2)
      begin : g_bad
         $error("mbrc_tick_div: DIV must be at least 2");
      end
   endgenerate

   assign cnt_next = (restart || last) ? '0 : cnt_reg + CW'(1);
   assign tick = last && !restart;

   always_ff @(posedge clk)
   begin
      if (reset)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end
endmodule
`default_nettype wire

// [rtl/mbrc_top.sv]
// Purpose: Opens and closes an external brake from drive state and limits
// Assumes: Drive inputs synchronous to CLK; settings written over APB
// Notes: BRAKE_RELEASE high opens the brake; delay unit is one tick
//
// Function
// - Release the brake only while the drive runs and every enabled torque and frequency limit is exceeded.
// - A stop command starts the brake-on delay count and the brake closes once frequency falls below the closing limit.
// - Failing that, the brake closes when the brake-on delay count expires.
// - A fault or the stop state closes the brake at once, without delay.
// - Second selector code 4 makes one shared frequency limit serve release and closing.
// - Both selectors at code 3 give separate release and closing frequency limits.
// - Torque and frequency limits may gate the brake together.
`timescale 1ns/1ps
`default_nettype none
module mbrc_top #(
   parameter int unsigned TICK_DIV = mbrc_pkg::TICK_CYCLES
) (
   input wire logic CLK,                  // 125 MHz system clock
   input wire logic RESET,                // Synchronous reset, active high
   input wire logic PSEL,                 // APB select
   input wire logic PENABLE,              // APB access phase
   input wire logic PWRITE,               // APB write
   input wire logic [7:0] PADDR,          // APB byte address
   input wire logic [31:0] PWDATA,        // APB write data
   output logic [31:0] PRDATA,            // APB read data
   output logic PREADY,                   // APB ready
   output logic PSLVERR,                  // APB error on unmapped address
   input wire logic DRV_RUN,              // Drive in run state
   input wire logic DRV_STOP_CMD,         // Stop command given
   input wire logic DRV_STOPPED,          // Drive in stop state
   input wire logic DRV_FAULT,            // Drive fault active
   input wire logic [15:0] DRV_TORQUE,    // Torque estimate
   input wire logic [15:0] DRV_FREQ,      // Output frequency estimate
   output logic BRAKE_RELEASE             // High opens the brake
);
   generate
      if (TICK_DIV < 2)
      begin : g_bad
         $error("mbrc_top: TICK_DIV must be at least 2");
      end
   endgenerate

   mbrc_pkg::mbrc_cfg_t cfg_reg;
   mbrc_pkg::mbrc_cfg_t cfg_next;
   mbrc_pkg::mbrc_drive_t drv;
   mbrc_pkg::mbrc_state_t state_reg;
   mbrc_pkg::mbrc_state_t state_next;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic release_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata;
   logic tick;

   assign drv = '{run: DRV_RUN, stop_cmd: DRV_STOP_CMD,
                  stopped: DRV_STOPPED, fault: DRV_FAULT,
                  torque: DRV_TORQUE, freq: DRV_FREQ};

   // APB decode
   wire setup = PSEL && !PENABLE;
   wire wr_en = PSEL && PENABLE && PWRITE;
   wire hit_ctrl = (PADDR == mbrc_pkg::OFS_CTRL);
   wire hit_sel = (PADDR == mbrc_pkg::OFS_SELECT);
   wire hit_fl1 = (PADDR == mbrc_pkg::OFS_FLIM_ONE);
   wire hit_fl2 = (PADDR == mbrc_pkg::OFS_FLIM_TWO);
   wire hit_tl = (PADDR == mbrc_pkg::OFS_TLIM);
   wire hit_dly = (PADDR == mbrc_pkg::OFS_ON_DELAY);
   wire hit_stat = (PADDR == mbrc_pkg::OFS_STATUS);
   wire mapped = hit_ctrl || hit_sel || hit_fl1 || hit_fl2 || hit_tl
                 || hit_dly || hit_stat;

   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA = prdata_reg;

   always_comb
   begin
      cfg_next = cfg_reg;
      if (wr_en && hit_ctrl)
         cfg_next.torque_en = PWDATA[mbrc_pkg::CTRL_TORQUE_EN_BIT];
      if (wr_en && hit_sel)
      begin
         cfg_next.sel_one = PWDATA[mbrc_pkg::SEL_ONE_LSB +: 3];
         cfg_next.sel_two = PWDATA[mbrc_pkg::SEL_TWO_LSB +: 3];
      end
      if (wr_en && hit_fl1)
         cfg_next.flim_one = PWDATA[15:0];
      if (wr_en && hit_fl2)
         cfg_next.flim_two = PWDATA[15:0];
      if (wr_en && hit_tl)
         cfg_next.tlim = PWDATA[15:0];
      if (wr_en && hit_dly)
         cfg_next.on_delay = PWDATA[15:0];
   end

   always_comb
   begin
      rdata = 32'h00000000;
      if (hit_ctrl)
         rdata[mbrc_pkg::CTRL_TORQUE_EN_BIT] = cfg_reg.torque_en;
      if (hit_sel)
      begin
         rdata[mbrc_pkg::SEL_ONE_LSB +: 3] = cfg_reg.sel_one;
         rdata[mbrc_pkg::SEL_TWO_LSB +: 3] = cfg_reg.sel_two;
      end
      if (hit_fl1)
         rdata[15:0] = cfg_reg.flim_one;
      if (hit_fl2)
         rdata[15:0] = cfg_reg.flim_two;
      if (hit_tl)
         rdata[15:0] = cfg_reg.tlim;
      if (hit_dly)
         rdata[15:0] = cfg_reg.on_delay;
      if (hit_stat)
      begin
         rdata[mbrc_pkg::STAT_STATE_LSB +: 2] = state_reg;
         rdata[mbrc_pkg::STAT_RELEASE_BIT] = release_reg;
         rdata[mbrc_pkg::STAT_COUNT_LSB +: 16] = count_reg;
      end
   end

   // Limit selection
   // shared limit
   wire shared_lim = (cfg_reg.sel_two == mbrc_pkg::SEL_SHARED);
   wire split_lim = (cfg_reg.sel_one == mbrc_pkg::SEL_SPLIT)
                    && (cfg_reg.sel_two == mbrc_pkg::SEL_SPLIT);
   wire freq_chk = shared_lim || split_lim;
   wire [15:0] rel_lim = shared_lim ? cfg_reg.flim_two : cfg_reg.flim_one;
   wire [15:0] close_lim = cfg_reg.flim_two;

   wire torque_ok = !cfg_reg.torque_en || (drv.torque > cfg_reg.tlim);
   wire freq_rel_ok = !freq_chk || (drv.freq > rel_lim);
   wire freq_below = freq_chk && (drv.freq < close_lim);
   wire release_ok = drv.run && torque_ok && freq_rel_ok;
   wire force_close = drv.fault || drv.stopped;
   wire expired = (count_reg >= cfg_reg.on_delay);
   wire counting = (state_reg == mbrc_pkg::MBRC_STOPPING);

   mbrc_tick_div #(
      .DIV(TICK_DIV)
   ) mbrc_tick_div_i (
      .clk(CLK),
      .reset(RESET),
      .restart(!counting),
      .tick(tick)
   );

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         mbrc_pkg::MBRC_CLOSED:
         begin
            count_next = 16'h0000;
            if (!force_close && !drv.stop_cmd && release_ok)
               state_next = mbrc_pkg::MBRC_RELEASED;
         end
         mbrc_pkg::MBRC_RELEASED:
         begin
            count_next = 16'h0000;
            if (force_close)
               state_next = mbrc_pkg::MBRC_CLOSED;
            else if (drv.stop_cmd)
               state_next = mbrc_pkg::MBRC_STOPPING;
            else if (!release_ok)
               state_next = mbrc_pkg::MBRC_CLOSED;
         end
         mbrc_pkg::MBRC_STOPPING:
         begin
            if (tick && !expired)
               count_next = count_reg + 16'h0001;
            if (force_close || freq_below || expired)
               state_next = mbrc_pkg::MBRC_CLOSED;
         end
         default:
         begin
            state_next = mbrc_pkg::MBRC_CLOSED;
            count_next = 16'h0000;
         end
      endcase
   end

   assign BRAKE_RELEASE = release_reg;

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         state_reg <= mbrc_pkg::MBRC_CLOSED;
         count_reg <= 16'h0000;
         release_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
         release_reg <= (state_next != mbrc_pkg::MBRC_CLOSED);
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RESET)
      begin
         cfg_reg.torque_en <= 1'b0;
         cfg_reg.sel_one <= mbrc_pkg::RST_SEL;
         cfg_reg.sel_two <= mbrc_pkg::RST_SEL;
         cfg_reg.flim_one <= mbrc_pkg::RST_LIMIT;
         cfg_reg.flim_two <= mbrc_pkg::RST_LIMIT;
         cfg_reg.tlim <= mbrc_pkg::RST_LIMIT;
         cfg_reg.on_delay <= mbrc_pkg::RST_ON_DELAY;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         cfg_reg <= cfg_next;
         if (setup && !PWRITE)
            prdata_reg <= rdata;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   sequence s_stop_taken;
      state_reg == mbrc_pkg::MBRC_RELEASED && drv.stop_cmd && !force_close;
   endsequence

   sequence s_counting_clear;
      state_reg == mbrc_pkg::MBRC_STOPPING && count_reg == 16'h0000;
   endsequence

   a_release_needs_run: assert property (
      $rose(BRAKE_RELEASE) |-> $past(drv.run && torque_ok && freq_rel_ok))
      else $error("Brake released without all conditions");

   a_stop_starts_count: assert property (
      s_stop_taken |=> s_counting_clear)
      else $error("Stop command did not start the delay count");

   a_close_below_limit: assert property (
      counting && freq_chk && drv.freq < close_lim |=> !BRAKE_RELEASE)
      else $error("Brake not closed below closing limit");

   a_delay_expiry: assert property (
      counting && count_reg >= cfg_reg.on_delay |=> !BRAKE_RELEASE)
      else $error("Brake not closed at delay expiry");

   a_fault_closes: assert property (
      (drv.fault || drv.stopped) |=> !BRAKE_RELEASE)
      else $error("Fault or stop state did not close the brake");

   a_shared_limit: assert property (
      cfg_reg.sel_two == 3'h4 |-> rel_lim == cfg_reg.flim_two
         && close_lim == cfg_reg.flim_two && freq_chk)
      else $error("Shared limit not applied");

   a_split_limits: assert property (
      cfg_reg.sel_one == 3'h3 && cfg_reg.sel_two == 3'h3
         |-> rel_lim == cfg_reg.flim_one && close_lim == cfg_reg.flim_two)
      else $error("Separate limits not applied");

   a_torque_and_freq: assert property (
      cfg_reg.torque_en && freq_chk && !BRAKE_RELEASE
         && (drv.torque <= cfg_reg.tlim || drv.freq <= rel_lim)
         |=> !BRAKE_RELEASE)
      else $error("Brake opened with a limit not exceeded");

   a_reset_closed: assert property (
      disable iff (1'b0) RESET |=> !BRAKE_RELEASE && count_reg == 16'h0000)
      else $error("Brake not closed after reset");

   a_output_follows: assert property (
      $changed(state_reg) |-> BRAKE_RELEASE
         == (state_reg != mbrc_pkg::MBRC_CLOSED))
      else $error("Brake output lags the decision");

   // A delay lowered by software mid-count to or below the current count closes the brake next cycle
   a_count_bounded: assert property (
      counting && $stable(cfg_reg.on_delay) |-> count_reg <= cfg_reg.on_delay)
      else $error("Delay count ran past the set delay");

   a_count_steps: assert property (
      counting && tick && !expired
         |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("Delay count did not step on a tick");

   a_stop_refuses: assert property (
      !BRAKE_RELEASE && drv.stop_cmd |=> !BRAKE_RELEASE)
      else $error("Brake released during a stop command");

   a_count_clear_idle: assert property (
      !counting |=> count_reg == 16'h0000)
      else $error("Delay count not cleared outside stopping");
endmodule
`default_nettype wire

// [sim/mbrc_brake_model.sv]
// Purpose: Brake actuator and relay at the far side of BRAKE_RELEASE
// Assumes: Relay pull-in and drop-out take RELAY_CYC clock cycles
// Notes: Brake is closed while reset holds or once the command has been low RELAY_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module mbrc_brake_model #(
   parameter int unsigned RELAY_CYC = 2
) (
   input wire logic clk,          // System clock
   input wire logic reset,        // Synchronous reset, active high
   input wire logic release_cmd,  // Brake release command
   output logic brake_open        // Brake mechanically open
);
   generate
      if (RELAY_CYC < 2)
      begin : g_bad
         $error("mbrc_brake_model: RELAY_CYC must be at least 2");
      end
   endgenerate
   logic [RELAY_CYC-1:0] pipe_reg;
   always_ff @(posedge clk)
   begin
      if (reset)
         pipe_reg <= '0;
      else
         pipe_reg <= {pipe_reg[RELAY_CYC-2:0], release_cmd};
   end
   assign brake_open = pipe_reg[RELAY_CYC-1];
endmodule
`default_nettype wire

// [sim/motor_brake_release_control_tb.sv]
// Purpose: Self-checking bench for the brake release control
// Assumes: TICK_DIV shortened to 4 cycles
// Notes: Drive inputs move at rising edges, checks at falling edges
`timescale 1ns/1ps
`default_nettype none
module motor_brake_release_control_tb;
   localparam int unsigned TDIV = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic brake;
   logic brake_open;
   mbrc_pkg::mbrc_drive_t drv = '0;
   logic [31:0] rd;
   logic err;
   logic c_en;
   logic [2:0] c_s1;
   logic [2:0] c_s2;
   logic [15:0] c_f1;
   logic [15:0] c_f2;
   logic [15:0] c_tl;
   logic [15:0] tq;
   logic [15:0] fq;
   int failures = 0;
   int total_checks = 0;
   int seed = 32'hF1BDE16C;
   int n;
   int j;
   mbrc_top #(.TICK_DIV(TDIV)) mbrc_top_i (
      .CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DRV_RUN(drv.run),
      .DRV_STOP_CMD(drv.stop_cmd), .DRV_STOPPED(drv.stopped),
      .DRV_FAULT(drv.fault), .DRV_TORQUE(drv.torque), .DRV_FREQ(drv.freq),
      .BRAKE_RELEASE(brake));
   mbrc_brake_model #(.RELAY_CYC(2)) mbrc_brake_model_i (
      .clk(clk), .reset(reset), .release_cmd(brake),
      .brake_open(brake_open));
   initial
   begin
      forever #4 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t bit %b exp %b", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 64);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         failures++;
         $display("MISMATCH t=%0t bus timeout", $time);
         results();
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic set_drv(input logic [3:0] st, input logic [15:0] t,
      input logic [15:0] f);
      @(posedge clk);
      drv <= {st, t, f};
   endtask
   task automatic cfg(input logic en, input logic [2:0] s1,
      input logic [2:0] s2, input logic [15:0] f1, input logic [15:0] f2,
      input logic [15:0] tl, input logic [15:0] dly);
      c_en = en;
      c_s1 = s1;
      c_s2 = s2;
      c_f1 = f1;
      c_f2 = f2;
      c_tl = tl;
      apb(1'b1, mbrc_pkg::OFS_CTRL, {31'h0, en});
      apb(1'b1, mbrc_pkg::OFS_SELECT, {25'h0, s2, 1'b0, s1});
      apb(1'b1, mbrc_pkg::OFS_FLIM_ONE, {16'h0, f1});
      apb(1'b1, mbrc_pkg::OFS_FLIM_TWO, {16'h0, f2});
      apb(1'b1, mbrc_pkg::OFS_TLIM, {16'h0, tl});
      apb(1'b1, mbrc_pkg::OFS_ON_DELAY, {16'h0, dly});
   endtask
   function automatic logic exp_rel(input logic [15:0] t,
      input logic [15:0] f);
      logic ok;
      ok = !c_en || t > c_tl;
      if (c_s2 == mbrc_pkg::SEL_SHARED)
         ok = ok && f > c_f2;
      else if (c_s1 == mbrc_pkg::SEL_SPLIT && c_s2 == mbrc_pkg::SEL_SPLIT)
         ok = ok && f > c_f1;
      return ok;
   endfunction
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      tick(0);
      chk1(brake, 1'b0);
      apb(1'b0, mbrc_pkg::OFS_ON_DELAY, 32'h0);
      chk32(rd, 32'h00000064);
      chk1(err, 1'b0);
      apb(1'b1, mbrc_pkg::OFS_STATUS, 32'hFFFFFFFF);
      apb(1'b0, mbrc_pkg::OFS_STATUS, 32'h0);
      chk32(rd, 32'h00000000);
      apb(1'b0, 8'h1C, 32'h0);
      chk1(err, 1'b1);
      chk32(rd, 32'h00000000);
      cfg(1'b0, 3'h0, 3'h4, 16'h0FFF, 16'h0100, 16'h0000, 16'h0064);
      apb(1'b0, mbrc_pkg::OFS_SELECT, 32'h0);
      chk32(rd, 32'h00000040);
      set_drv(4'b1000, 16'h0000, 16'h0200);
      tick(1);
      chk1(brake, 1'b1);
      tick(2);
      chk1(brake_open, 1'b1);
      apb(1'b0, mbrc_pkg::OFS_STATUS, 32'h0);
      chk32(rd, 32'h00000005);
      set_drv(4'b1100, 16'h0000, 16'h0100);
      tick(2);
      chk1(brake, 1'b1);
      set_drv(4'b1100, 16'h0000, 16'h00FF);
      tick(1);
      chk1(brake, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         set_drv(4'b1000, 16'h0000, 16'h0200);
         tick(1);
         chk1(brake, 1'b1);
         set_drv({1'b1, 3'(3'b001 << i) | (i == 2 ? 3'b101 : 3'b000)},
            16'h0000, 16'h0200);
         tick(1);
         chk1(brake, 1'b0);
      end
      cfg(1'b1, 3'h3, 3'h3, 16'h0300, 16'h0100, 16'h0050, 16'h0064);
      set_drv(4'b1000, 16'h0060, 16'h0200);
      tick(2);
      chk1(brake, 1'b0);
      set_drv(4'b1000, 16'h0050, 16'h0301);
      tick(2);
      chk1(brake, 1'b0);
      set_drv(4'b1000, 16'h0051, 16'h0301);
      tick(1);
      chk1(brake, 1'b1);
      set_drv(4'b1100, 16'h0051, 16'h0200);
      tick(2);
      chk1(brake, 1'b1);
      set_drv(4'b1100, 16'h0051, 16'h00FF);
      tick(1);
      chk1(brake, 1'b0);
      // frequency check off so the brake-on delay alone closes the brake
      cfg(1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000, 16'h0000, 16'h0003);
      set_drv(4'b1000, 16'h0000, 16'h0000);
      tick(1);
      chk1(brake, 1'b1);
      set_drv(4'b1100, 16'h0000, 16'h0000);
      tick(8);
      chk1(brake, 1'b1);
      n = 8;
      while (brake !== 1'b0 && n < 3 * TDIV + 4)
      begin
         tick(1);
         n++;
      end
      chk1(n >= 3 * TDIV && n <= 3 * TDIV + 3, 1'b1);
      // Reset in mid-count must close the brake and clear the count
      set_drv(4'b1000, 16'h0000, 16'h0000);
      tick(1);
      chk1(brake, 1'b1);
      set_drv(4'b1100, 16'h0000, 16'h0000);
      tick(6);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      tick(0);
      chk1(brake, 1'b0);
      apb(1'b0, mbrc_pkg::OFS_STATUS, 32'h0);
      chk32(rd, 32'h00000000);
      apb(1'b0, mbrc_pkg::OFS_ON_DELAY, 32'h0);
      chk32(rd, 32'h00000064);
      for (int i = 0; i < 24; i++)
      begin
         set_drv(4'b0000, 16'h0000, 16'h0000);
         j = $unsigned($random(seed)) % 3;
         cfg(1'($random(seed)), j == 1 ? 3'h3 : 3'h0,
            j == 0 ? 3'h4 : (j == 1 ? 3'h3 : 3'h0),
            16'($random(seed)), 16'($random(seed)), 16'($random(seed)),
            16'h0064);
         tq = c_tl + 16'($random(seed) % 2);
         fq = (j == 0 ? c_f2 : c_f1) + 16'($random(seed) % 2);
         set_drv(4'b1000, tq, fq);
         tick(1);
         chk1(brake, exp_rel(tq, fq));
      end
      results();
   end
endmodule
`default_nettype wire
